/* File: vic_regs.vh */
/*
  Register map, field positions, reset values and vector layout of the
  vectored interrupt controller.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define VIC_OFS_ENABLE   8'h00
`define VIC_OFS_FLAGS    8'h04
`define VIC_OFS_SRC_FLAG 8'h08
`define VIC_OFS_SRC_EN   8'h0C
`define VIC_OFS_PIN_CFG  8'h10
`define VIC_OFS_STATUS   8'h14

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define VIC_RST_ENABLE   12'h000
`define VIC_RST_FLAGS    11'h000
`define VIC_RST_SRC      16'h0000
`define VIC_RST_PIN_CFG  16'h0000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VIC_GIE_BIT      0
`define VIC_EN_LSB       1
`define VIC_IDX_EXT0     0
`define VIC_IDX_CMP      4
`define VIC_IDX_CONV     5
`define VIC_IDX_GRP0     6
`define VIC_CFG_FSEL_LSB 8
`define VIC_CFG_DIR_LSB  12
`define VIC_SRC_LOW_SUP  14
`define VIC_SRC_NVM      15

// ----------------------------------------------------------------
// edge select codes, two bits per pin
// ----------------------------------------------------------------
`define VIC_EDGE_OFF     2'h0
`define VIC_EDGE_RISE    2'h1
`define VIC_EDGE_FALL    2'h2
`define VIC_EDGE_BOTH    2'h3

// ----------------------------------------------------------------
// grouped source membership
// ----------------------------------------------------------------
`define VIC_GRP0_MASK    16'h000F
`define VIC_GRP1_MASK    16'h00F0
`define VIC_GRP2_MASK    16'h0300
`define VIC_GRP3_MASK    16'hC000
`define VIC_GRP4_MASK    16'h3C00

// ----------------------------------------------------------------
// vector addresses: base plus step per index, ascending with index
// ----------------------------------------------------------------
`define VIC_VEC_BASE     12'h004
`define VIC_VEC_STEP     12'h004

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define VIC_RESP_OKAY    2'h0
`define VIC_RESP_SLVERR  2'h2

`endif

/* File: vic_top.v */
/*
  Vectored interrupt controller: request flags, enables, pin edge
  detection, fixed priority selection, vector request to the core,
  automatic flag clearing on service and low-power wake-up.
  Assumes the core pulses IRQ_ACK for one cycle when it takes the
  presented vector, pushes its own PC and reports a full stack level.
*/
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "vic_regs.vh"

module vic_top #(
  parameter NPIN = 4,
  parameter NSTD = 3,
  parameter NPER = 4
) (
  // clock and reset
  input wire CLOCK,
  input wire RESET_N,
  // axi4-lite slave
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // event sources
  input wire [NPIN-1:0] EXT_IRQ_PINS,
  input wire CMP_OUT,
  input wire CONV_DONE,
  input wire LOW_SUPPLY_DETECT,
  input wire NVM_WRITE_DONE,
  input wire [NSTD-1:0] STD_TIMER_PERIOD_MATCH,
  input wire [NSTD-1:0] STD_TIMER_CMPA_MATCH,
  input wire [NPER-1:0] PER_TIMER_PERIOD_MATCH,
  input wire [NPER-1:0] PER_TIMER_CMPA_MATCH,
  // processor core
  input wire STACK_FULL,
  input wire IRQ_ACK,
  output reg IRQ_REQ,
  output reg [11:0] IRQ_VECTOR,
  output reg WAKE
);

  localparam NGRP = 5;
  localparam NIRQ = 11;
  localparam NSRC = 16;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg global_irq_enable;
  reg [NIRQ-1:0] irq_enable;
  reg [NIRQ-1:0] irq_flag;
  reg [NSRC-1:0] src_flag;
  reg [NSRC-1:0] src_enable;
  reg [15:0] pin_cfg;
  reg [NSRC-1:0] src_prev;
  reg [NIRQ-1:0] flag_prev;
  reg [3:0] sel_idx;
  reg [NPIN-1:0] pin_s1;
  reg [NPIN-1:0] pin_s2;
  reg [NPIN-1:0] pin_s3;
  reg cmp_s1;
  reg cmp_s2;
  reg cmp_s3;
  reg lvd_s1;
  reg lvd_s2;
  reg lvd_s3;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // two stages for async levels, a third for edge history
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      pin_s1 <= {NPIN{1'b0}};
      pin_s2 <= {NPIN{1'b0}};
      pin_s3 <= {NPIN{1'b0}};
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_s3 <= 1'b0;
      lvd_s1 <= 1'b0;
      lvd_s2 <= 1'b0;
      lvd_s3 <= 1'b0;
    end else begin
      pin_s1 <= EXT_IRQ_PINS;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      cmp_s1 <= CMP_OUT;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      lvd_s1 <= LOW_SUPPLY_DETECT;
      lvd_s2 <= lvd_s1;
      lvd_s3 <= lvd_s2;
    end
  end

  // ----------------------------------------------------------------
  // hardware set events
  // ----------------------------------------------------------------
  reg [NIRQ-1:0] hw_set;
  reg [NSRC-1:0] src_set;
  reg [NGRP-1:0] grp_set;
  reg [NSRC-1:0] src_rise;
  reg [1:0] edge_mode;
  reg pin_live;
  integer i;

  // group membership lookup
  function [NSRC-1:0] grp_mask;
    input integer g;
    begin
      case (g)
        0: grp_mask = `VIC_GRP0_MASK;
        1: grp_mask = `VIC_GRP1_MASK;
        2: grp_mask = `VIC_GRP2_MASK;
        3: grp_mask = `VIC_GRP3_MASK;
        default: grp_mask = `VIC_GRP4_MASK;
      endcase
    end
  endfunction

  // edge detection and source events
  always @* begin
    hw_set = {NIRQ{1'b0}};
    src_set = {NSRC{1'b0}};
    grp_set = {NGRP{1'b0}};
    edge_mode = `VIC_EDGE_OFF;
    pin_live = 1'b0;
    for (i = 0; i < NPIN; i = i + 1) begin
      edge_mode = pin_cfg[2*i +: 2];
      pin_live = irq_enable[`VIC_IDX_EXT0 + i] & pin_cfg[`VIC_CFG_FSEL_LSB + i]
               & pin_cfg[`VIC_CFG_DIR_LSB + i];
      case (edge_mode)
        `VIC_EDGE_RISE: hw_set[i] = pin_live & pin_s2[i] & ~pin_s3[i];
        `VIC_EDGE_FALL: hw_set[i] = pin_live & ~pin_s2[i] & pin_s3[i];
        `VIC_EDGE_BOTH: hw_set[i] = pin_live & (pin_s2[i] ^ pin_s3[i]);
        default: hw_set[i] = 1'b0;
      endcase
    end
    hw_set[`VIC_IDX_CMP] = cmp_s2 ^ cmp_s3;
    hw_set[`VIC_IDX_CONV] = CONV_DONE;
    // timer k: bit 2k period, bit 2k+1 compare-A
    src_set[0] = STD_TIMER_PERIOD_MATCH[0];
    src_set[1] = STD_TIMER_CMPA_MATCH[0];
    src_set[2] = PER_TIMER_PERIOD_MATCH[0];
    src_set[3] = PER_TIMER_CMPA_MATCH[0];
    src_set[4] = STD_TIMER_PERIOD_MATCH[1];
    src_set[5] = STD_TIMER_CMPA_MATCH[1];
    src_set[6] = PER_TIMER_PERIOD_MATCH[1];
    src_set[7] = PER_TIMER_CMPA_MATCH[1];
    src_set[8] = PER_TIMER_PERIOD_MATCH[2];
    src_set[9] = PER_TIMER_CMPA_MATCH[2];
    src_set[10] = STD_TIMER_PERIOD_MATCH[2];
    src_set[11] = STD_TIMER_CMPA_MATCH[2];
    src_set[12] = PER_TIMER_PERIOD_MATCH[3];
    src_set[13] = PER_TIMER_CMPA_MATCH[3];
    src_set[`VIC_SRC_LOW_SUP] = lvd_s2 & ~lvd_s3;
    src_set[`VIC_SRC_NVM] = NVM_WRITE_DONE;
    src_rise = src_flag & ~src_prev;
    for (i = 0; i < NGRP; i = i + 1) begin
      grp_set[i] = |(src_rise & grp_mask(i));
    end
    hw_set[NIRQ-1:`VIC_IDX_GRP0] = grp_set;
  end

  // ----------------------------------------------------------------
  // pending requests and priority
  // ----------------------------------------------------------------
  reg [NIRQ-1:0] pend;
  reg any_pend;
  reg [3:0] next_idx;
  reg next_req;
  integer k;

  // lowest index wins, which is also the lowest vector
  always @* begin
    pend = irq_flag & irq_enable;
    for (k = 0; k < NGRP; k = k + 1) begin
      pend[`VIC_IDX_GRP0 + k] = pend[`VIC_IDX_GRP0 + k]
                              & |(src_flag & src_enable & grp_mask(k));
    end
    any_pend = |pend;
    next_idx = 4'h0;
    for (k = NIRQ - 1; k >= 0; k = k - 1) begin
      if (pend[k]) begin
        next_idx = k[3:0];
      end
    end
    // global enable, free stack, not in the taking cycle
    next_req = global_irq_enable & ~STACK_FULL & any_pend & ~IRQ_ACK;
  end

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  wire wr_fire;
  wire [31:0] wmask;

  assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
  assign S_AXI_WREADY = ~w_held & ~S_AXI_BVALID;
  assign wr_fire = aw_held & w_held & ~S_AXI_BVALID;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  wire wr_en = wr_fire & (aw_addr == `VIC_OFS_ENABLE);
  wire wr_flg = wr_fire & (aw_addr == `VIC_OFS_FLAGS);
  wire wr_sfl = wr_fire & (aw_addr == `VIC_OFS_SRC_FLAG);
  wire wr_sen = wr_fire & (aw_addr == `VIC_OFS_SRC_EN);
  wire wr_cfg = wr_fire & (aw_addr == `VIC_OFS_PIN_CFG);
  wire wr_ok = wr_en | wr_flg | wr_sfl | wr_sen | wr_cfg
             | (wr_fire & (aw_addr == `VIC_OFS_STATUS));

  // address and data held independently, response after both
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `VIC_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // flags, enables and configuration
  // ----------------------------------------------------------------
  wire [31:0] en_word = {20'h0, irq_enable, global_irq_enable};
  wire [31:0] en_new = (en_word & ~wmask) | (w_data & wmask);
  wire [31:0] flg_word = {21'h0, irq_flag};
  wire [31:0] flg_new = (flg_word & ~wmask) | (w_data & wmask);
  wire [31:0] sfl_word = {16'h0, src_flag};
  wire [31:0] sfl_new = (sfl_word & ~wmask) | (w_data & wmask);
  wire [31:0] sen_word = {16'h0, src_enable};
  wire [31:0] sen_new = (sen_word & ~wmask) | (w_data & wmask);
  wire [31:0] cfg_word = {16'h0, pin_cfg};
  wire [31:0] cfg_new = (cfg_word & ~wmask) | (w_data & wmask);
  wire [NIRQ-1:0] ack_clr = IRQ_ACK ? ({{(NIRQ-1){1'b0}}, 1'b1} << sel_idx) : {NIRQ{1'b0}};
  wire [NIRQ-1:0] flg_bwr = wr_flg ? wmask[NIRQ-1:0] : {NIRQ{1'b0}};
  wire [NSRC-1:0] sfl_bwr = wr_sfl ? wmask[NSRC-1:0] : {NSRC{1'b0}};

  // software write first, then hardware set, then service clear
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      {irq_enable, global_irq_enable} <= `VIC_RST_ENABLE;
      irq_flag <= `VIC_RST_FLAGS;
      src_flag <= `VIC_RST_SRC;
      src_enable <= `VIC_RST_SRC;
      pin_cfg <= `VIC_RST_PIN_CFG;
      src_prev <= `VIC_RST_SRC;
      flag_prev <= `VIC_RST_FLAGS;
    end else begin
      if (wr_en) begin
        {irq_enable, global_irq_enable} <= en_new[NIRQ:0];
      end else if (IRQ_ACK) begin
        global_irq_enable <= 1'b0;
      end
      // held until serviced or cleared
      irq_flag <= (flg_new[NIRQ-1:0] & flg_bwr)
                | (~flg_bwr & (hw_set | (irq_flag & ~ack_clr)));
      src_flag <= (sfl_new[NSRC-1:0] & sfl_bwr) | (~sfl_bwr & (src_set | src_flag));
      if (wr_sen) begin
        src_enable <= sen_new[NSRC-1:0];
      end
      if (wr_cfg) begin
        pin_cfg <= cfg_new[15:0];
      end
      src_prev <= src_flag;
      flag_prev <= irq_flag;
    end
  end

  // ----------------------------------------------------------------
  // core request, vector and wake-up
  // ----------------------------------------------------------------
  // vector and index reloaded from the current winner on every cycle the request stands
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      IRQ_REQ <= 1'b0;
      IRQ_VECTOR <= `VIC_VEC_BASE;
      sel_idx <= 4'h0;
      WAKE <= 1'b0;
    end else begin
      IRQ_REQ <= next_req;
      if (next_req) begin
        sel_idx <= next_idx;
        IRQ_VECTOR <= `VIC_VEC_BASE + `VIC_VEC_STEP * {8'h00, next_idx};
      end
      // any rising flag, enables ignored
      WAKE <= |(irq_flag & ~flag_prev) | |(src_flag & ~src_prev);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  reg [31:0] rd_word;
  reg rd_hit;

  // read mux
  always @* begin
    rd_hit = 1'b1;
    case ({S_AXI_ARADDR[7:2], 2'b00})
      `VIC_OFS_ENABLE: rd_word = en_word;
      `VIC_OFS_FLAGS: rd_word = flg_word;
      `VIC_OFS_SRC_FLAG: rd_word = sfl_word;
      `VIC_OFS_SRC_EN: rd_word = sen_word;
      `VIC_OFS_PIN_CFG: rd_word = cfg_word;
      `VIC_OFS_STATUS: rd_word = {4'h0, IRQ_VECTOR, 8'h00, sel_idx, 1'b0, WAKE, STACK_FULL, IRQ_REQ};
      default: begin
        rd_word = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  // one read outstanding, answer registered
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `VIC_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_word;
      S_AXI_RRESP <= rd_hit ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

/* File: vic_core_model.sv */
/*
  Behavioural processor core facing the vector request of the controller.
  Assumes one shared clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module vic_core_model #(
  parameter DEPTH = 6
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // vector request
  input wire irq_req,
  input wire [11:0] irq_vector,
  output reg irq_ack,
  output wire stack_full,
  // bench controls
  input wire [3:0] lat,
  input wire pop
);
  reg [4:0] depth;
  reg [3:0] cnt;
  reg [11:0] pc;
  // return stack level
  assign stack_full = (depth == 5'(DEPTH));
  // take the vector after lat cycles, push pc and jump
  always @(posedge clk) begin
    if (!rst_n) begin
      depth <= 5'h0;
      cnt <= 4'h0;
      irq_ack <= 1'b0;
      pc <= 12'h100;
    end else begin
      irq_ack <= 1'b0;
      cnt <= 4'h0;
      if (pop && depth != 5'h0) depth <= depth - 5'h1;
      if (irq_req && !irq_ack && !stack_full) begin
        cnt <= cnt + 4'h1;
        if (cnt == lat) begin
          irq_ack <= 1'b1;
          depth <= depth + 5'h1;
          pc <= irq_vector;
        end
      end
    end
  end
endmodule

/* File: vic_top_asserts.sv */
/*
  Port assertions for the interrupt controller top.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module vic_top_asserts (
  // clock and reset
  input wire CLOCK,
  input wire RESET_N,
  // register bus
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // processor core
  input wire STACK_FULL,
  input wire IRQ_ACK,
  input wire IRQ_REQ,
  input wire [11:0] IRQ_VECTOR
);
  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);
  // handshake steps
  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence vec_taken;
    IRQ_REQ && IRQ_ACK;
  endsequence
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_wr_answer: assert property (wr_taken |-> ##[1:2] S_AXI_BVALID)
    else $error("write response missing");
  a_rd_answer: assert property (rd_taken |=> S_AXI_RVALID)
    else $error("read response missing");
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped early");
  a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
    else $error("read response dropped early");
  a_wr_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted during response");
  a_rd_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read accepted during response");
  a_ack_ends_req: assert property (vec_taken |=> !IRQ_REQ [*2])
    else $error("request stays after service");
  a_full_blocks: assert property (STACK_FULL && !IRQ_REQ |=> !IRQ_REQ)
    else $error("request raised on full stack");
  a_vec_legal: assert property (IRQ_REQ |-> IRQ_VECTOR[1:0] == 2'h0 &&
    IRQ_VECTOR inside {[12'h004:12'h02C]})
    else $error("vector outside table");
endmodule

/* File: vic_top_bench.sv */
/*
  Self-checking bench for the interrupt controller top with a core model.
  Assumes the register header, the design and the core model compiled first.
*/
`timescale 1ns/1ns
`include "vic_regs.vh"
module vic_top_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [1:0] ok = `VIC_RESP_OKAY;
  localparam logic [7:0] r_en = `VIC_OFS_ENABLE;
  localparam logic [7:0] r_fl = `VIC_OFS_FLAGS;
  localparam logic [7:0] r_sf = `VIC_OFS_SRC_FLAG;
  localparam logic [7:0] r_se = `VIC_OFS_SRC_EN;
  logic clock = 1'b0, reset_n = 1'b0, aw_valid = 1'b0, w_valid = 1'b0;
  logic b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0, pop = 1'b0;
  logic cmp = 1'b0, conv = 1'b0, low = 1'b0, nvm = 1'b0;
  logic [7:0] aw_addr = 8'h0, ar_addr = 8'h0;
  logic [31:0] w_data = 32'h0, rv;
  logic [3:0] pins = 4'h0, lat = 4'h0, perp = 4'h0, pera = 4'h0;
  logic [2:0] stdp = 3'h0, stda = 3'h0;
  logic [11:0] exp_q[$];
  logic [11:0] ev;
  wire aw_ready, w_ready, b_valid, ar_ready, r_valid, irq_ack, stack_full, irq_req, wake;
  wire [1:0] b_resp, r_resp;
  wire [31:0] r_data;
  wire [11:0] irq_vec;
  integer n_fail = 0, n_checks = 0, n_ack = 0, n_wake = 0, w0, i, seed = 32'h5A1E;
  // ----------------------------------------------------------------
  // design and core
  // ----------------------------------------------------------------
  vic_top u_dut (
    .CLOCK(clock), .RESET_N(reset_n), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
    .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp),
    .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr),
    .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data),
    .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready),
    .EXT_IRQ_PINS(pins), .CMP_OUT(cmp), .CONV_DONE(conv), .LOW_SUPPLY_DETECT(low),
    .NVM_WRITE_DONE(nvm), .STD_TIMER_PERIOD_MATCH(stdp), .STD_TIMER_CMPA_MATCH(stda),
    .PER_TIMER_PERIOD_MATCH(perp), .PER_TIMER_CMPA_MATCH(pera), .STACK_FULL(stack_full),
    .IRQ_ACK(irq_ack), .IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vec), .WAKE(wake)
  );
  vic_core_model #(.DEPTH(6)) u_core (
    .clk(clock), .rst_n(reset_n), .irq_req(irq_req), .irq_vector(irq_vec),
    .irq_ack(irq_ack), .stack_full(stack_full), .lat(lat), .pop(pop)
  );
  // clock
  initial begin
    forever #20 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bus write, answer taken where bvalid meets bready
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    integer t;
    logic ta, tw, tb;
    t = 0;
    tb = 1'b0;
    @(posedge clock);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    while (!tb && t < 100) begin
      @(negedge clock);
      ta = aw_valid && aw_ready;
      tw = w_valid && w_ready;
      tb = b_ready && b_valid;
      if (tb) chk("bresp", {30'h0, er}, {30'h0, b_resp});
      @(posedge clock);
      t++;
      if (ta) aw_valid <= 1'b0;
      if (tw) w_valid <= 1'b0;
    end
    b_ready <= 1'b0;
    if (!tb) chk("write_wait", 32'h1, 32'h0);
  endtask
  // bus read compared with the expected word
  task automatic axr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] e);
    integer t;
    logic ta, tb;
    t = 0;
    tb = 1'b0;
    @(posedge clock);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    while (!tb && t < 100) begin
      @(negedge clock);
      ta = ar_valid && ar_ready;
      tb = r_ready && r_valid;
      if (tb) chk("rresp", {30'h0, er}, {30'h0, r_resp});
      if (tb) chk("rdata", e, r_data);
      @(posedge clock);
      t++;
      if (ta) ar_valid <= 1'b0;
    end
    r_ready <= 1'b0;
    if (!tb) chk("read_wait", 32'h1, 32'h0);
  endtask
  task automatic pulse_conv;
    @(posedge clock);
    conv <= 1'b1;
    @(posedge clock);
    conv <= 1'b0;
  endtask
  task automatic wait_ack(input integer n);
    integer t;
    t = 0;
    while (n_ack < n && t < 200) begin
      @(posedge clock);
      t++;
    end
    chk("acks", n, n_ack);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // monitors and watchdog
  // ----------------------------------------------------------------
  // vector offered at each service against the queued expectation
  always @(negedge clock) begin
    if (irq_ack === 1'b1) begin
      n_ack++;
      ev = 12'hFFF;
      if (exp_q.size() > 0) ev = exp_q.pop_front();
      chk("vector", {20'h0, ev}, {20'h0, irq_vec});
    end
    if (wake === 1'b1) n_wake++;
  end
  initial begin
    #(40 * 10000);
    n_fail++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    for (i = 0; i < 5; i++) axr(8'(4 * i), ok, 32'h0);
    axr(`VIC_OFS_STATUS, ok, {4'h0, `VIC_VEC_BASE, 16'h0});
    axr(8'h18, `VIC_RESP_SLVERR, 32'h0);
    axw(8'h18, 32'hFFFF, `VIC_RESP_SLVERR);
    rv = $random(seed);
    lat <= {2'h0, rv[17:16]};
    axw(r_se, rv, ok);
    axr(r_se, ok, {16'h0, rv[15:0]});
    // flag kept and wake raised while the global enable is off
    axw(r_en, 32'h40, ok);
    w0 = n_wake;
    pulse_conv();
    repeat (3) @(posedge clock);
    axr(r_fl, ok, 32'h20);
    chk("req_off", 32'h0, {31'h0, irq_req});
    chk("wake", w0 + 1, n_wake);
    pulse_conv();
    repeat (3) @(posedge clock);
    chk("wake_preset", w0 + 1, n_wake);
    // edge codes on pin 0, comparator toggling alongside
    axw(r_en, 32'h2, ok);
    for (i = 0; i < 5; i++) begin
      axw(`VIC_OFS_PIN_CFG, (i == 4) ? 32'h1003 : 32'h1100 + i, ok);
      axw(r_fl, 32'h0, ok);
      pins <= 4'h1;
      cmp <= 1'b1;
      repeat (6) @(posedge clock);
      axr(r_fl, ok, 32'h10 + (i == 1 || i == 3));
      axw(r_fl, 32'h0, ok);
      pins <= 4'h0;
      cmp <= 1'b0;
      repeat (6) @(posedge clock);
      axr(r_fl, ok, 32'h10 + (i == 2 || i == 3));
    end
    // six own-vector flags served lowest vector first
    axw(r_fl, 32'h3F, ok);
    axw(r_en, 32'h7E, ok);
    for (i = 0; i < 6; i++) begin
      exp_q.push_back(12'h004 + 12'(4 * i));
      axw(r_en, 32'h7F, ok);
      wait_ack(i + 1);
      axr(r_fl, ok, (32'h3F << (i + 1)) & 32'h3F);
      axr(r_en, ok, 32'h7E);
    end
    // full return stack holds the request back until a pop
    pulse_conv();
    axw(r_en, 32'h7F, ok);
    repeat (8) @(posedge clock);
    chk("req_full", 32'h0, {31'h0, irq_req});
    exp_q.push_back(12'h018);
    pop <= 1'b1;
    @(posedge clock);
    pop <= 1'b0;
    wait_ack(7);
    axr(r_fl, ok, 32'h0);
    axr(r_en, ok, 32'h7E);
    pop <= 1'b1;
    repeat (6) @(posedge clock);
    pop <= 1'b0;
    // low supply served through group 3, source flag left set
    axw(r_se, 32'h4000, ok);
    exp_q.push_back(12'h028);
    axw(r_en, 32'h401, ok);
    low <= 1'b1;
    wait_ack(8);
    axr(r_sf, ok, 32'h4000);
    axr(r_fl, ok, 32'h0);
    axr(r_en, ok, 32'h400);
    // remaining grouped sources only raise flags
    nvm <= 1'b1;
    stdp <= 3'h7;
    stda <= 3'h7;
    perp <= 4'hF;
    pera <= 4'hF;
    @(posedge clock);
    nvm <= 1'b0;
    stdp <= 3'h0;
    stda <= 3'h0;
    perp <= 4'h0;
    pera <= 4'h0;
    repeat (3) @(posedge clock);
    axr(r_sf, ok, 32'hFFFF);
    axr(r_fl, ok, 32'h7C0);
    // second reset in mid-run
    low <= 1'b0;
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    axr(r_sf, ok, 32'h0);
    axr(r_en, ok, 32'h0);
    axr(`VIC_OFS_STATUS, ok, {4'h0, `VIC_VEC_BASE, 16'h0});
    give_verdict();
  end
endmodule
bind vic_top vic_top_asserts u_chk (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .STACK_FULL(STACK_FULL), .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR)
);
